// >>> hw/nfc_cyc_if.sv
// bus cycle request and answer between sequencer and pin engine
`default_nettype none
interface nfc_cyc_if;
  logic req;
  logic we;
  logic byte_mode;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport ctl (output req, we, byte_mode, addr, wdata, input done, rdata);
  modport cyc (input req, we, byte_mode, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// >>> hw/nfc_cycle.sv
// one asynchronous read or write cycle on the flash pins
`default_nettype none
module nfc_cycle
  import nfc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // sequencer side
  nfc_cyc_if.cyc cif,
  // flash pins
  input wire logic [15:0] i_fl_data,
  output logic [19:0] o_fl_addr,
  output logic o_fl_alsb,
  output logic [15:0] o_fl_data,
  output logic [15:0] o_fl_data_oe,
  output logic o_fl_ce_n,
  output logic o_fl_we_n,
  output logic o_fl_oe_n
);
  nfc_cyc_st_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic we_r;
  logic bm_r;
  logic [15:0] d_s1_r;
  logic [15:0] d_s2_r;

  // data pins cross in through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      d_s1_r <= DATA_RST_VAL;
      d_s2_r <= DATA_RST_VAL;
    end else if (i_ce) begin
      d_s1_r <= i_fl_data;
      d_s2_r <= d_s1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= CY_IDLE;
      cnt_r <= '0;
      we_r <= 1'b0;
      bm_r <= 1'b0;
      o_fl_addr <= '0;
      o_fl_alsb <= 1'b0;
      o_fl_data <= DATA_RST_VAL;
      o_fl_data_oe <= '0;
      o_fl_ce_n <= 1'b1;
      o_fl_we_n <= 1'b1;
      o_fl_oe_n <= 1'b1;
      cif.done <= 1'b0;
      cif.rdata <= DATA_RST_VAL;
    end else if (i_ce) begin
      cif.done <= 1'b0;
      case (st_r)
        CY_IDLE: begin
          if (!cif.byte_mode) o_fl_alsb <= 1'b0; // [RULE2]
          if (cif.req) begin
            we_r <= cif.we;
            bm_r <= cif.byte_mode;
            // byte mode takes a-1 as lowest address bit [RULE2]
            o_fl_addr <= cif.byte_mode ? cif.addr[20:1] : cif.addr[19:0];
            o_fl_alsb <= cif.byte_mode & cif.addr[0];
            o_fl_data <= cif.byte_mode ? {8'h00, cif.wdata[7:0]} : cif.wdata;
            o_fl_ce_n <= 1'b0;
            if (cif.we) begin
              // only low lines driven in byte mode [RULE1]
              o_fl_data_oe <= cif.byte_mode ? 16'h00ff : 16'hffff;
              cnt_r <= CNT_W'(CYC_SETUP - 1);
              st_r <= CY_SETUP;
            end else begin
              // data bus left to device during read [RULE4]
              o_fl_oe_n <= 1'b0;
              cnt_r <= CNT_W'(CYC_READ - 1);
              st_r <= CY_PULSE;
            end
          end
        end
        CY_SETUP: begin
          if (cnt_r == '0) begin
            // command written as a plain bus write [RULE5]
            o_fl_we_n <= 1'b0;
            cnt_r <= CNT_W'(CYC_WE - 1);
            st_r <= CY_PULSE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        CY_PULSE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (we_r) begin
            o_fl_we_n <= 1'b1;
            cnt_r <= CNT_W'(CYC_HOLD - 1);
            st_r <= CY_HOLD;
          end else begin
            cif.rdata <= bm_r ? {8'h00, d_s2_r[7:0]} : d_s2_r; // [RULE1]
            o_fl_oe_n <= 1'b1;
            o_fl_ce_n <= 1'b1;
            cif.done <= 1'b1;
            st_r <= CY_IDLE;
          end
        end
        CY_HOLD: begin
          if (cnt_r == '0) begin
            o_fl_ce_n <= 1'b1;
            o_fl_data_oe <= '0;
            cif.done <= 1'b1;
            st_r <= CY_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= CY_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hw/nfc_host.sv
// host controller for a parallel nor flash: registers, sequences, polling
// Contract
// [RULE1] x16 uses all lines, x8 low eight
// [RULE2] byte or word addressing of the array
// [RULE3] fixed sector layout, halved in word mode
// [RULE4] separate active-low select, write, output enable
// [RULE5] commands are ordinary bus write cycles
// [RULE6] device latches address and data per write
// [RULE7] program runs its own internal algorithm
// [RULE8] bypass program two writes, otherwise four
// [RULE9] erase runs its own internal algorithm
// [RULE10] busy shown by pin, poll and toggle
// [RULE11] after completion device reads and accepts commands
// [RULE12] erase touches only selected sectors
// [RULE13] writes ignored during low supply
// [RULE14] protected sectors refuse program and erase
// [RULE15] erase suspend allows other-sector reads and programs
// [RULE16] reset pin aborts and returns to read
// [RULE17] stable address enters automatic sleep
// [RULE18] host can put device in standby
// [RULE19] write-protect low guards boot sector
// [RULE20] secured serial number region, lockable
// [RULE21] temporary unprotect of locked sectors
// [RULE22] locking in-system or by programmer
// [RULE23] reads during busy return status bits
//
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module nfc_host
  import nfc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // flash pins
  input wire logic [15:0] i_fl_data,
  input wire logic i_fl_ready_busy_n,
  output logic [19:0] o_fl_addr,
  output logic o_fl_alsb,
  output logic [15:0] o_fl_data,
  output logic [15:0] o_fl_data_oe,
  output logic o_fl_ce_n,
  output logic o_fl_we_n,
  output logic o_fl_oe_n,
  output logic o_fl_reset_n,
  output logic o_fl_wp_n,
  output logic o_fl_byte_n
);
  nfc_cyc_if cif ();
  nfc_host_st_t st_r;
  logic byte_mode_r;
  logic wp_on_r;
  logic [20:0] addr_r;
  logic [15:0] wdata_r;
  logic [3:0] op_r;
  logic [2:0] step_r;
  logic last_r;
  logic [CNT_W-1:0] cnt_r;
  logic req_r;
  logic cwe_r;
  logic [20:0] caddr_r;
  logic [15:0] cdata_r;
  logic [15:0] t1_r;
  logic [15:0] rdata_r;
  logic fin_r;
  logic bypass_r;
  logic erase_run_r;
  logic susp_r;
  logic refused_r;
  logic done_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic cmd_go;
  logic rst_go;
  logic op_ok;
  logic busy;
  nfc_seq_t seq;

  // write cycles of each command sequence
  function automatic nfc_seq_t seq_step(input logic [3:0] op, input logic [2:0] step,
      input logic byp, input logic bm, input logic [20:0] a, input logic [15:0] d);
    nfc_seq_t s;
    logic [20:0] u1;
    logic [20:0] u2;
    u1 = bm ? UNLK1_B : UNLK1_W;
    u2 = bm ? UNLK2_B : UNLK2_W;
    s = '{last: 1'b1, addr: a, data: CB_RESET};
    case (op)
      OP_PROGRAM: begin
        if (byp) begin
          // two writes in bypass mode [RULE8]
          s.last = (step == 3'd1);
          s.data = (step == 3'd0) ? CB_PROG : d;
        end else begin
          // four writes in normal mode [RULE8]
          s.last = (step == 3'd3);
          case (step)
            3'd0: s = '{last: 1'b0, addr: u1, data: CB_UNLOCK1};
            3'd1: s = '{last: 1'b0, addr: u2, data: CB_UNLOCK2};
            3'd2: s = '{last: 1'b0, addr: u1, data: CB_PROG};
            default: s.data = d;
          endcase
        end
      end
      OP_SECT_ERASE, OP_CHIP_ERASE: begin
        s.last = (step == 3'd5);
        case (step)
          3'd0, 3'd3: s = '{last: 1'b0, addr: u1, data: CB_UNLOCK1};
          3'd1, 3'd4: s = '{last: 1'b0, addr: u2, data: CB_UNLOCK2};
          3'd2: s = '{last: 1'b0, addr: u1, data: CB_ERASE_SETUP};
          default: begin
            s.addr = (op == OP_CHIP_ERASE) ? u1 : a;
            s.data = (op == OP_CHIP_ERASE) ? CB_CHIP_ERASE : CB_SECT_ERASE;
          end
        endcase
      end
      OP_BYP_ON: begin
        s.last = (step == 3'd2);
        case (step)
          3'd0: s = '{last: 1'b0, addr: u1, data: CB_UNLOCK1};
          3'd1: s = '{last: 1'b0, addr: u2, data: CB_UNLOCK2};
          default: s = '{last: 1'b1, addr: u1, data: CB_BYPASS};
        endcase
      end
      OP_BYP_OFF: begin
        s.last = (step == 3'd1);
        s.data = (step == 3'd0) ? CB_BYP_EXIT1 : CB_BYP_EXIT2;
      end
      OP_SUSPEND: s.data = CB_SUSPEND;
      OP_RESUME: s.data = CB_RESUME;
      default: s.data = CB_RESET;
    endcase
    return s;
  endfunction

  assign seq = seq_step(op_r, step_r, bypass_r, byte_mode_r, addr_r, wdata_r);
  assign busy = (st_r != HS_IDLE) || fin_r;
  assign cmd_go = i_ce && i_wr && (i_addr == REG_CMD);
  assign rst_go = i_ce && i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_RST_BIT];
  assign cif.req = req_r;
  assign cif.we = cwe_r;
  assign cif.byte_mode = byte_mode_r;
  assign cif.addr = caddr_r;
  assign cif.wdata = cdata_r;

  // legality of a new operation
  always_comb begin
    case (i_wdata[3:0])
      OP_READ, OP_RESET, OP_POLL: op_ok = 1'b1;
      OP_PROGRAM: op_ok = !erase_run_r || susp_r; // [RULE15]
      OP_SECT_ERASE, OP_CHIP_ERASE: op_ok = !erase_run_r;
      OP_SUSPEND: op_ok = erase_run_r && !susp_r;
      OP_RESUME: op_ok = susp_r;
      OP_BYP_ON, OP_BYP_OFF: op_ok = !erase_run_r;
      default: op_ok = 1'b0;
    endcase
  end

  // ready/busy pin through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else if (i_ce) begin
      rb_s1_r <= i_fl_ready_busy_n;
      rb_s2_r <= rb_s1_r;
    end
  end

  // software registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      byte_mode_r <= CTRL_RST_VAL[CTRL_BYTE_BIT];
      wp_on_r <= CTRL_RST_VAL[CTRL_WP_BIT];
      addr_r <= ADDR_RST_VAL;
      wdata_r <= DATA_RST_VAL;
      o_fl_byte_n <= 1'b1;
      o_fl_wp_n <= 1'b1;
    end else if (i_ce) begin
      if (i_wr && !busy) begin
        case (i_addr)
          REG_CTRL: begin
            byte_mode_r <= i_wdata[CTRL_BYTE_BIT];
            wp_on_r <= i_wdata[CTRL_WP_BIT];
          end
          REG_ADDR: addr_r <= i_wdata[20:0];
          REG_WDATA: wdata_r <= i_wdata[15:0];
          default: ;
        endcase
      end
      o_fl_byte_n <= !byte_mode_r; // [RULE1]
      o_fl_wp_n <= !wp_on_r; // [RULE19]
    end
  end

  // sequencer
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= HS_IDLE;
      op_r <= OP_NONE;
      step_r <= '0;
      last_r <= 1'b0;
      cnt_r <= '0;
      req_r <= 1'b0;
      cwe_r <= 1'b0;
      caddr_r <= ADDR_RST_VAL;
      cdata_r <= DATA_RST_VAL;
      t1_r <= DATA_RST_VAL;
      rdata_r <= DATA_RST_VAL;
      fin_r <= 1'b0;
      o_fl_reset_n <= 1'b1;
    end else if (i_ce) begin
      req_r <= 1'b0;
      fin_r <= 1'b0;
      if (rst_go) begin
        // reset pin aborts whatever runs [RULE16]
        o_fl_reset_n <= 1'b0;
        cnt_r <= CNT_W'(CYC_RST_LOW - 1);
        st_r <= HS_RSTLOW;
      end else begin
        case (st_r)
          HS_IDLE: begin
            // chip select stays high: device in standby [RULE18]
            if (cmd_go && op_ok && !fin_r) begin
              op_r <= i_wdata[3:0];
              step_r <= '0;
              if (i_wdata[3:0] == OP_READ) begin
                st_r <= HS_READ;
              end else if (i_wdata[3:0] == OP_POLL) begin
                st_r <= HS_POLLA;
              end else begin
                st_r <= HS_ISSUE;
              end
            end
          end
          HS_ISSUE: begin
            req_r <= 1'b1;
            cwe_r <= 1'b1;
            caddr_r <= seq.addr;
            cdata_r <= seq.data;
            last_r <= seq.last;
            st_r <= HS_WAITW;
          end
          HS_WAITW: begin
            if (cif.done) begin
              if (!last_r) begin
                step_r <= step_r + 3'd1;
                st_r <= HS_ISSUE;
              end else if (op_r == OP_PROGRAM || op_r == OP_SUSPEND) begin
                st_r <= HS_POLLA; // [RULE7]
              end else begin
                // erase left running so it can be suspended [RULE9]
                fin_r <= 1'b1;
                st_r <= HS_IDLE;
              end
            end
          end
          HS_READ: begin
            req_r <= 1'b1;
            cwe_r <= 1'b0;
            caddr_r <= addr_r;
            st_r <= HS_WAITR;
          end
          HS_WAITR: begin
            if (cif.done) begin
              rdata_r <= cif.rdata;
              fin_r <= 1'b1;
              st_r <= HS_IDLE;
            end
          end
          HS_POLLA, HS_POLLB: begin
            req_r <= 1'b1;
            cwe_r <= 1'b0;
            caddr_r <= addr_r;
            st_r <= (st_r == HS_POLLA) ? HS_WAITA : HS_WAITB;
          end
          HS_WAITA: begin
            if (cif.done) begin
              t1_r <= cif.rdata; // [RULE23]
              st_r <= HS_POLLB;
            end
          end
          HS_WAITB: begin
            if (cif.done) begin
              rdata_r <= cif.rdata;
              // toggle bit stops when the device is done [RULE10]
              if (cif.rdata[TOGGLE_BIT] == t1_r[TOGGLE_BIT]) begin
                fin_r <= 1'b1;
                st_r <= HS_IDLE; // [RULE11]
              end else begin
                t1_r <= cif.rdata;
                st_r <= HS_POLLB;
              end
            end
          end
          HS_RSTLOW: begin
            if (cnt_r == '0) begin
              o_fl_reset_n <= 1'b1;
              cnt_r <= CNT_W'(CYC_RST_READY - 1);
              st_r <= HS_RSTWAIT;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          HS_RSTWAIT: begin
            if (cnt_r == '0) begin
              st_r <= HS_IDLE;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          default: st_r <= HS_IDLE;
        endcase
      end
    end
  end

  // mode and sticky status flags
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bypass_r <= 1'b0;
      erase_run_r <= 1'b0;
      susp_r <= 1'b0;
      refused_r <= 1'b0;
      done_r <= 1'b0;
    end else if (i_ce) begin
      if (rst_go) begin
        bypass_r <= 1'b0; // [RULE16]
        erase_run_r <= 1'b0;
        susp_r <= 1'b0;
      end else if (fin_r) begin
        case (op_r)
          OP_SECT_ERASE, OP_CHIP_ERASE: erase_run_r <= 1'b1;
          OP_SUSPEND: susp_r <= 1'b1; // [RULE15]
          OP_RESUME: susp_r <= 1'b0;
          OP_POLL: erase_run_r <= susp_r;
          OP_BYP_ON: bypass_r <= 1'b1; // [RULE8]
          OP_BYP_OFF: bypass_r <= 1'b0;
          default: ;
        endcase
      end
      if (cmd_go && (busy || !op_ok)) begin
        refused_r <= 1'b1;
      end else if (i_wr && i_addr == REG_STATUS && i_wdata[ST_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
      if (fin_r) begin
        done_r <= 1'b1;
      end else if (i_wr && i_addr == REG_STATUS && i_wdata[ST_DONE_BIT]) begin
        done_r <= 1'b0;
      end
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        case (i_addr)
          REG_CTRL: o_rdata <= {30'h0, wp_on_r, byte_mode_r};
          REG_ADDR: o_rdata <= {11'h0, addr_r};
          REG_WDATA: o_rdata <= {16'h0, wdata_r};
          REG_CMD: o_rdata <= {28'h0, op_r};
          REG_STATUS: o_rdata <= {25'h0, done_r, refused_r, susp_r, erase_run_r,
                                  bypass_r, rb_s2_r, busy}; // [RULE10]
          REG_RDATA: o_rdata <= {16'h0, rdata_r};
          default: o_rdata <= '0;
        endcase
      end
    end
  end

  nfc_cycle u_cycle (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .cif(cif.cyc),
    .i_fl_data(i_fl_data),
    .o_fl_addr(o_fl_addr),
    .o_fl_alsb(o_fl_alsb),
    .o_fl_data(o_fl_data),
    .o_fl_data_oe(o_fl_data_oe),
    .o_fl_ce_n(o_fl_ce_n),
    .o_fl_we_n(o_fl_we_n),
    .o_fl_oe_n(o_fl_oe_n)
  );
endmodule
`default_nettype wire

// >>> hw/nfc_pkg.sv
// constants and types for the nor flash host controller
`default_nettype none
package nfc_pkg;
  // widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CNT_W = 12;
  // clock and pin timing
  localparam int CLK_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_READ_NS = 80;
  localparam int T_RST_LOW_NS = 500;
  localparam int T_RST_READY_NS = 20000;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CYC_SETUP = ns2cyc(T_SETUP_NS);
  localparam int CYC_WE = ns2cyc(T_WE_NS);
  localparam int CYC_HOLD = ns2cyc(T_HOLD_NS);
  localparam int CYC_READ = ns2cyc(T_READ_NS);
  localparam int CYC_RST_LOW = ns2cyc(T_RST_LOW_NS);
  localparam int CYC_RST_READY = ns2cyc(T_RST_READY_NS);
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  // field positions
  localparam int CTRL_BYTE_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_BYPASS_BIT = 2;
  localparam int ST_ERASE_BIT = 3;
  localparam int ST_SUSP_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int ST_DONE_BIT = 6;
  localparam int TOGGLE_BIT = 6;
  // reset values
  localparam logic [1:0] CTRL_RST_VAL = 2'h0;
  localparam logic [20:0] ADDR_RST_VAL = 21'h000000;
  localparam logic [15:0] DATA_RST_VAL = 16'h0000;
  // operation codes written to the command register
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_SECT_ERASE = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_SUSPEND = 4'h5;
  localparam logic [3:0] OP_RESUME = 4'h6;
  localparam logic [3:0] OP_RESET = 4'h7;
  localparam logic [3:0] OP_BYP_ON = 4'h8;
  localparam logic [3:0] OP_BYP_OFF = 4'h9;
  localparam logic [3:0] OP_POLL = 4'ha;
  // command cycle addresses and values
  localparam logic [20:0] UNLK1_W = 21'h000555;
  localparam logic [20:0] UNLK2_W = 21'h0002aa;
  localparam logic [20:0] UNLK1_B = 21'h000aaa;
  localparam logic [20:0] UNLK2_B = 21'h000555;
  localparam logic [15:0] CB_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CB_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CB_PROG = 16'h00a0;
  localparam logic [15:0] CB_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CB_SECT_ERASE = 16'h0030;
  localparam logic [15:0] CB_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CB_SUSPEND = 16'h00b0;
  localparam logic [15:0] CB_RESUME = 16'h0030;
  localparam logic [15:0] CB_RESET = 16'h00f0;
  localparam logic [15:0] CB_BYPASS = 16'h0020;
  localparam logic [15:0] CB_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] CB_BYP_EXIT2 = 16'h0000;
  // types
  typedef struct packed {
    logic last;
    logic [20:0] addr;
    logic [15:0] data;
  } nfc_seq_t;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} nfc_cyc_st_t;
  typedef enum logic [3:0] {
    HS_IDLE, HS_ISSUE, HS_WAITW, HS_READ, HS_WAITR, HS_POLLA, HS_WAITA,
    HS_POLLB, HS_WAITB, HS_RSTLOW, HS_RSTWAIT
  } nfc_host_st_t;
endpackage
`default_nettype wire

// >>> verif/nfc_flash_model.sv
// behavioural nor flash part facing the host controller
`default_nettype none
module nfc_flash_model (
  // control pins
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_reset_n,
  input wire logic i_wp_n,
  // address and data
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [15:0] prev = 16'h0000;
  logic [15:0] rdv = 16'h0000;
  logic byp = 1'b0, susp = 1'b0, tog = 1'b0;
  int busy = 0, nwr = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(posedge i_we_n) if (!i_ce_n && i_reset_n) begin
    nwr++;
    if (prev[7:0] == 8'ha0 && busy == 0) begin
      if (i_wp_n || i_addr[19:13] != 7'h00) begin
        mem[i_addr[7:0]] = i_data;
      end
      busy = 4;
    end else if (i_data[7:0] == 8'h20 && prev[7:0] == 8'h55) byp = 1'b1;
    else if (i_data[7:0] == 8'h00 && prev[7:0] == 8'h90) byp = 1'b0;
    else if (i_data[7:0] == 8'hb0) susp = 1'b1;
    else if (i_data[7:0] == 8'h30 && susp) susp = 1'b0;
    else if (i_data[7:0] == 8'h30) busy = 12;
    prev = i_data;
  end
  always @(negedge i_oe_n) if (!i_ce_n) begin
    if (busy > 0 && !susp) begin
      busy--;
      tog = ~tog;
    end
    rdv = (busy > 0 && !susp) ? {9'h000, tog, 6'h00} : mem[i_addr[7:0]];
  end
  always @(negedge i_reset_n) begin
    busy = 0;
    susp = 1'b0;
    byp = 1'b0;
  end
  // released lines show the inverse of the last value
  assign o_data = (!i_ce_n && !i_oe_n) ? rdv : ~rdv;
  assign o_ready_busy_n = !(busy > 0 && !susp);
endmodule
`default_nettype wire

// >>> verif/nfc_host_assertions.sv
// port assertions for the nor flash host controller
`default_nettype none
module nfc_host_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // flash pins
  input wire logic [19:0] o_fl_addr,
  input wire logic o_fl_alsb,
  input wire logic [15:0] o_fl_data,
  input wire logic [15:0] o_fl_data_oe,
  input wire logic o_fl_ce_n,
  input wire logic o_fl_we_n,
  input wire logic o_fl_oe_n,
  input wire logic o_fl_reset_n,
  input wire logic o_fl_byte_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_we_in_ce; !o_fl_we_n |-> !o_fl_ce_n; endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe without select");
  property p_no_both; !(!o_fl_we_n && !o_fl_oe_n); endproperty
  a_no_both: assert property (p_no_both) else $error("write and output enable both low");
  property p_oe_nodrive; !o_fl_oe_n |-> o_fl_data_oe == 16'h0000; endproperty
  a_oe_nodrive: assert property (p_oe_nodrive) else $error("driving while device drives");
  property p_ce_lead; $fell(o_fl_we_n) |-> $past(o_fl_ce_n, 3) && !$past(o_fl_ce_n, 2); endproperty
  a_ce_lead: assert property (p_ce_lead) else $error("select lead wrong");
  property p_we_width; $fell(o_fl_we_n) |-> !o_fl_we_n [*4] ##1 o_fl_we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
  property p_ce_hold; $rose(o_fl_we_n) |-> !o_fl_ce_n [*2] ##1 o_fl_ce_n; endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("select hold after write wrong");
  property p_latch;
    !o_fl_we_n && !$past(o_fl_we_n) |-> $stable(o_fl_addr) && $stable(o_fl_data);
  endproperty
  a_latch: assert property (p_latch) else $error("address or data moved");
  property p_bus_width;
    !o_fl_we_n |-> o_fl_data_oe == (o_fl_byte_n ? 16'hffff : 16'h00ff);
  endproperty
  a_bus_width: assert property (p_bus_width) else $error("driven lines wrong for mode");
  property p_word_alsb; o_fl_byte_n |-> !o_fl_alsb; endproperty
  a_word_alsb: assert property (p_word_alsb) else $error("low address bit in word mode");
  property p_rst_pulse; $fell(o_fl_reset_n) |-> ##49 !o_fl_reset_n ##1 o_fl_reset_n; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");
  c_write: cover property ($fell(o_fl_we_n));
  c_read: cover property ($fell(o_fl_oe_n));
  c_reset: cover property ($fell(o_fl_reset_n));
endmodule
bind nfc_host nfc_host_assertions u_assert (.i_clk(i_clk), .i_rstn(i_rstn),
  .o_fl_addr(o_fl_addr), .o_fl_alsb(o_fl_alsb), .o_fl_data(o_fl_data),
  .o_fl_data_oe(o_fl_data_oe), .o_fl_ce_n(o_fl_ce_n), .o_fl_we_n(o_fl_we_n),
  .o_fl_oe_n(o_fl_oe_n), .o_fl_reset_n(o_fl_reset_n), .o_fl_byte_n(o_fl_byte_n));
`default_nettype wire

// >>> verif/parallel_nor_flash_command_control_tb_top.sv
// register-level bench for the nor flash host controller
`default_nettype none
module parallel_nor_flash_command_control_tb_top;
  import nfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rstn, i_wr, i_rd, rbn, oen, wen, cen, rstn_fl, wpn, bytn, alsb;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, s;
  logic [19:0] fa;
  logic [15:0] fd, foe, md, dq;
  int failures = 0;
  int comparisons = 0;
  int n0;
  assign dq = (fd & foe) | (md & ~foe);
  nfc_host DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fl_data(dq),
    .i_fl_ready_busy_n(rbn), .o_fl_addr(fa), .o_fl_alsb(alsb), .o_fl_data(fd),
    .o_fl_data_oe(foe), .o_fl_ce_n(cen), .o_fl_we_n(wen), .o_fl_oe_n(oen),
    .o_fl_reset_n(rstn_fl), .o_fl_wp_n(wpn), .o_fl_byte_n(bytn));
  nfc_flash_model u_fl (.i_ce_n(cen), .i_we_n(wen), .i_oe_n(oen), .i_reset_n(rstn_fl),
    .i_wp_n(wpn), .i_addr(fa), .i_data(dq), .o_data(md), .o_ready_busy_n(rbn));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic conclude();
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic idle();
    for (int n = 0; n < 3000; n++) begin
      rd(REG_STATUS, s);
      if (s[ST_BUSY_BIT] === 1'b0) return;
    end
    failures++;
    conclude();
  endtask
  task automatic op(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d);
    wr(REG_ADDR, {11'h000, a});
    wr(REG_WDATA, {16'h0000, d});
    wr(REG_CMD, {28'h0000000, c});
    idle();
  endtask
  initial begin
    i_rstn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h00000000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd(REG_STATUS, s);
    chk(s, 32'h00000002, "status after reset");
    n0 = u_fl.nwr;
    op(OP_PROGRAM, 21'h000123, 16'ha55a);
    chk(u_fl.nwr - n0, 4, "normal program writes");
    chk({16'h0000, u_fl.mem[8'h23]}, 32'h0000a55a, "programmed word");
    chk(s[ST_DONE_BIT], 1'b1, "done flag");
    op(OP_READ, 21'h000123, 16'h0000);
    rd(REG_RDATA, s);
    chk(s, 32'h0000a55a, "read back");
    op(OP_BYP_ON, 21'h000000, 16'h0000);
    rd(REG_STATUS, s);
    chk(s[ST_BYPASS_BIT], 1'b1, "bypass flag");
    n0 = u_fl.nwr;
    op(OP_PROGRAM, 21'h000050, 16'h5a3c);
    chk(u_fl.nwr - n0, 2, "bypass program writes");
    op(OP_BYP_OFF, 21'h000000, 16'h0000);
    chk(u_fl.byp, 1'b0, "bypass left");
    wr(REG_CTRL, 32'h00000002);
    @(posedge i_clk);
    #1 chk(wpn, 1'b0, "write protect pin");
    op(OP_PROGRAM, 21'h000010, 16'h1234);
    chk({16'h0000, u_fl.mem[8'h10]}, 32'h0000ffff, "boot sector guarded");
    wr(REG_CTRL, 32'h00000001);
    @(posedge i_clk);
    #1 chk(bytn, 1'b0, "byte mode pin");
    op(OP_PROGRAM, 21'h000081, 16'h00c3);
    chk({16'h0000, u_fl.mem[8'h40]}, 32'h000000c3, "byte address split");
    wr(REG_CTRL, 32'h00000000);
    wr(REG_CMD, 32'h0000000b);
    rd(REG_STATUS, s);
    chk(s[ST_REFUSED_BIT], 1'b1, "illegal op refused");
    wr(REG_STATUS, 32'h00000020);
    rd(8'h20, s);
    chk(s, 32'h00000000, "unmapped read");
    op(OP_SECT_ERASE, 21'h010000, 16'h0000);
    chk(s[ST_ERASE_BIT], 1'b1, "erase running");
    op(OP_SUSPEND, 21'h010000, 16'h0000);
    chk(s[ST_SUSP_BIT], 1'b1, "suspended");
    op(OP_READ, 21'h000123, 16'h0000);
    rd(REG_RDATA, s);
    chk(s, 32'h0000a55a, "read while suspended");
    op(OP_RESUME, 21'h010000, 16'h0000);
    chk(s[ST_SUSP_BIT], 1'b0, "resumed");
    op(OP_POLL, 21'h010000, 16'h0000);
    chk(rbn, 1'b1, "erase finished");
    op(OP_BYP_ON, 21'h000000, 16'h0000);
    wr(REG_CTRL, 32'h00000004);
    idle();
    chk(s & 32'h0000001c, 32'h00000000, "flags after reset");
    conclude();
  end
endmodule
`default_nettype wire
